// file: src/tcc_consts.svh
// Register offsets, field positions and bus codes of the timer channel block
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

`define TCC_MAP_BITS      6
`define TCC_GRP_MSB       5
`define TCC_GRP_LSB       4
`define TCC_CH_MSB        3
`define TCC_CH_LSB        2
`define TCC_GRP_CTRL      2'h0
`define TCC_GRP_VALH      2'h1
`define TCC_GRP_VALL      2'h2
`define TCC_GRP_DMA       2'h3
`define TCC_OFS_CTRL0     8'h00
`define TCC_OFS_VALH0     8'h10
`define TCC_OFS_VALL0     8'h20
`define TCC_OFS_DMA       8'h30
`define TCC_CTRL_RST      8'h00
`define TCC_DMA_RST       4'h0
`define TCC_FLAG_BIT      7
`define TCC_BYTE_W        8
`define TCC_RESP_OKAY     2'h0
`define TCC_RESP_SLVERR   2'h2
`define TCC_ELS_OFF       2'h0
`define TCC_ELS_TOGGLE    2'h1
`define TCC_ELS_CLEAR     2'h2
`define TCC_ELS_SET       2'h3
`define TCC_ELS_RISE      2'h1
`define TCC_ELS_FALL      2'h2

`endif

// file: src/tcc_pkg.sv
// Types shared by the timer channel block
package tcc_pkg;

    typedef struct packed {
        logic       flag;       // channel_event_flag
        logic       irq_en;     // channel_irq_enable
        logic       buf_sel;    // buffered_mode_select
        logic       msa;        // mode_select_a
        logic [1:0] els;        // edge_level_high_bit, edge_level_low_bit
        logic       tov;        // overflow_toggle
        logic       max;        // full_duty_force
    } tcc_ctrl_s;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_CAPTURE,
        MODE_COMPARE
    } tcc_mode_e;

endpackage : tcc_pkg

// file: src/tcc_top.sv
// Four capture/compare/PWM channels of a 16-bit timer, AXI4-Lite registers
`timescale 1ns/10ps
`include "tcc_consts.svh"
// How it works
// R1 - CPU route: read control with flag set, then write 0 clears flag.
// R2 - Event arriving during that clear sequence keeps the flag set.
// R3 - Enable plus DMA route: any low-byte access clears the flag.
// R4 - Software keeps DMA route off for buffered channels.
// R5 - Writing 1 to flag does nothing; reset clears all control bits.
// R6 - Flag reads 1 after capture or match, else 0.
// R7 - Enable gates requests; route picks CPU or DMA outside buffered mode.
// R8 - Buffered bit lives on channels 0/2; disables partner, frees its pin.
// R9 - Buffered bit set enables buffered compare on the pair.
// R10 - Edge/level 00: mode bit A 1 presets pin low, 0 high.
// R11 - Edge/level nonzero: mode A picks capture/compare if pair unbuffered.
// R12 - Software stops and resets timer before changing mode bits.
// R13 - Edge/level 00 releases the pin to port control.
// R14 - Capture edge: 01 rising, 10 falling, 11 both.
// R15 - Match action: 01 toggle, 10 low, 11 high.
// R16 - Pin kept stable two clocks before capture is enabled.
// R17 - Overflow toggle bit toggles pin on overflow in compare modes.
// R18 - Overflow action beats a match in the same cycle.
// R19 - Full duty forces pin high one cycle late; flags keep setting.
// R20 - Capture latches counter value on the selected edge.
// R21 - Reading high byte blocks captures until low byte read.
// R22 - Software writes overwrite captures; idle value regs are storage.
// R23 - Matches blocked between high and low writes of active value.
// R24 - Buffered pair alternates; inactive low write swaps at overflow.
module tcc_top #(
    parameter int NUM_CH = 4,
    parameter int CNT_W  = 16,
    parameter int ADDR_W = 8
) (
    input  wire logic              ref_clk_i,           // 125 MHz clock
    input  wire logic              reset_n_i,           // Async reset
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,      // Write address
    input  wire logic              s_axi_awvalid_i,     // Write addr valid
    output logic                   s_axi_awready_o,     // Write addr ready
    input  wire logic [31:0]       s_axi_wdata_i,       // Write data
    input  wire logic [3:0]        s_axi_wstrb_i,       // Byte enables
    input  wire logic              s_axi_wvalid_i,      // Write data valid
    output logic                   s_axi_wready_o,      // Write data ready
    output logic [1:0]             s_axi_bresp_o,       // Write response
    output logic                   s_axi_bvalid_o,      // Write resp valid
    input  wire logic              s_axi_bready_i,      // Write resp ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,      // Read address
    input  wire logic              s_axi_arvalid_i,     // Read addr valid
    output logic                   s_axi_arready_o,     // Read addr ready
    output logic [31:0]            s_axi_rdata_o,       // Read data
    output logic [1:0]             s_axi_rresp_o,       // Read response
    output logic                   s_axi_rvalid_o,      // Read data valid
    input  wire logic              s_axi_rready_i,      // Read data ready
    input  wire logic [CNT_W-1:0]  timer_count_value_i, // Shared counter
    input  wire logic              timer_ovf_i,         // Overflow pulse
    input  wire logic [NUM_CH-1:0] channel_pin_i,       // Pin level in
    output logic [NUM_CH-1:0]      channel_pin_o,       // Pin level out
    output logic [NUM_CH-1:0]      channel_pin_oe_o,    // Pin drive enable
    output logic [NUM_CH-1:0]      cpu_irq_o,           // CPU requests
    output logic [NUM_CH-1:0]      dma_req_o            // DMA requests
);

    if (NUM_CH != 4 || CNT_W != 16 || ADDR_W <= `TCC_MAP_BITS) begin : g_chk
        $error("tcc_top: needs 4 channels, 16-bit counter, address > 6");
    end

    // Bus slave
    logic              aw_rdy_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              ar_rdy_r;
    logic              rvalid_r;
    logic [1:0]        rresp_r;
    logic [31:0]       rdata_r;
    logic              wr_fire;
    logic              rd_fire;
    logic [1:0]        wgrp;
    logic [1:0]        rgrp;
    logic [1:0]        wch;
    logic [1:0]        rch;
    logic              w_ok;
    logic              r_ok;
    logic [7:0]        wbyte;
    logic [31:0]       rd_mux;

    // Channel state
    tcc_pkg::tcc_ctrl_s ctrl_r [NUM_CH];
    logic [CNT_W-1:0]  val_r [NUM_CH];
    logic [NUM_CH-1:0] dma_r;
    logic [NUM_CH-1:0] hi_pend_r;
    logic [NUM_CH-1:0] cap_blk_r;
    logic [NUM_CH-1:0] clr_arm_r;
    logic [NUM_CH-1:0] out_r;
    logic [NUM_CH-1:0] filt_r;
    logic [1:0]        act_r;
    logic [1:0]        swap_arm_r;
    logic [NUM_CH-1:0] wr_ctrl;
    logic [NUM_CH-1:0] wr_hi;
    logic [NUM_CH-1:0] wr_lo;
    logic [NUM_CH-1:0] rd_ctrl;
    logic [NUM_CH-1:0] rd_hi;
    logic [NUM_CH-1:0] rd_lo;
    logic [NUM_CH-1:0] pbuf;
    logic [NUM_CH-1:0] ev;
    logic [NUM_CH-1:0] cap_ev;
    logic [NUM_CH-1:0] match;
    logic [NUM_CH-1:0] out_nxt;
    tcc_pkg::tcc_mode_e mode [NUM_CH];

    assign wr_fire = aw_rdy_r & s_axi_awvalid_i & s_axi_wvalid_i;
    assign rd_fire = ar_rdy_r & s_axi_arvalid_i;
    assign wgrp    = s_axi_awaddr_i[`TCC_GRP_MSB:`TCC_GRP_LSB];
    assign wch     = s_axi_awaddr_i[`TCC_CH_MSB:`TCC_CH_LSB];
    assign rgrp    = s_axi_araddr_i[`TCC_GRP_MSB:`TCC_GRP_LSB];
    assign rch     = s_axi_araddr_i[`TCC_CH_MSB:`TCC_CH_LSB];
    assign wbyte   = s_axi_wdata_i[`TCC_BYTE_W-1:0];
    assign w_ok    = s_axi_awaddr_i[1:0] == 2'h0
                   && s_axi_awaddr_i[ADDR_W-1:`TCC_MAP_BITS] == '0
                   && !(wgrp == `TCC_GRP_DMA && wch != 2'h0);
    assign r_ok    = s_axi_araddr_i[1:0] == 2'h0
                   && s_axi_araddr_i[ADDR_W-1:`TCC_MAP_BITS] == '0
                   && !(rgrp == `TCC_GRP_DMA && rch != 2'h0);

    // Both write channels are taken in one beat; simpler than two holds
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_rdy_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r  <= `TCC_RESP_OKAY;
        end else begin
            aw_rdy_r <= !aw_rdy_r && !bvalid_r && s_axi_awvalid_i
                        && s_axi_wvalid_i;
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r  <= w_ok ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ar_rdy_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r  <= `TCC_RESP_OKAY;
            rdata_r  <= '0;
        end else begin
            ar_rdy_r <= !ar_rdy_r && !rvalid_r && s_axi_arvalid_i;
            if (rd_fire) begin
                rvalid_r <= 1'b1;
                rresp_r  <= r_ok ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
                rdata_r  <= r_ok ? rd_mux : '0;
            end else if (s_axi_rready_i) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_mux = '0;
        case (rgrp)
            `TCC_GRP_CTRL: rd_mux[7:0] = ctrl_r[rch];
            `TCC_GRP_VALH: rd_mux[7:0] = val_r[rch][CNT_W-1:`TCC_BYTE_W];
            `TCC_GRP_VALL: rd_mux[7:0] = val_r[rch][`TCC_BYTE_W-1:0];
            default:       rd_mux[NUM_CH-1:0] = dma_r;
        endcase
    end

    assign s_axi_awready_o = aw_rdy_r;
    assign s_axi_wready_o  = aw_rdy_r;
    assign s_axi_bvalid_o  = bvalid_r;
    assign s_axi_bresp_o   = bresp_r;
    assign s_axi_arready_o = ar_rdy_r;
    assign s_axi_rvalid_o  = rvalid_r;
    assign s_axi_rresp_o   = rresp_r;
    assign s_axi_rdata_o   = rdata_r;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dma_r <= `TCC_DMA_RST;
        end else if (wr_fire && w_ok && s_axi_wstrb_i[0]
                     && wgrp == `TCC_GRP_DMA) begin
            dma_r <= wbyte[NUM_CH-1:0];
        end
    end

    // Buffered pair: active value swaps only at a period boundary
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            act_r      <= 2'h0;
            swap_arm_r <= 2'h0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (!pbuf[2*p]) begin
                    act_r[p]      <= 1'b0;
                    swap_arm_r[p] <= 1'b0;
                end else if (timer_ovf_i && swap_arm_r[p]) begin
                    act_r[p]      <= ~act_r[p];                  // [R24]
                    swap_arm_r[p] <= 1'b0;
                end else if (wr_lo[2*p + {1'b0, ~act_r[p]}]) begin
                    swap_arm_r[p] <= 1'b1;                       // [R24]
                end
            end
        end
    end

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        localparam int EVN = c - (c % 2);
        localparam int PR  = c / 2;
        logic [2:0]       sync_r;
        logic             edge_hit;
        logic [CNT_W-1:0] cmp_val;
        logic             inhibit;
        logic             clr_req;
        logic             irq_r;
        logic             dreq_r;
        logic             pin_r;
        logic             oe_r;

        wire w_sel = wr_fire && w_ok && s_axi_wstrb_i[0] && wch == c;
        wire r_sel = rd_fire && r_ok && rch == c;
        assign wr_ctrl[c] = w_sel && wgrp == `TCC_GRP_CTRL;
        assign wr_hi[c]   = w_sel && wgrp == `TCC_GRP_VALH;
        assign wr_lo[c]   = w_sel && wgrp == `TCC_GRP_VALL;
        assign rd_ctrl[c] = r_sel && rgrp == `TCC_GRP_CTRL;
        assign rd_hi[c]   = r_sel && rgrp == `TCC_GRP_VALH;
        assign rd_lo[c]   = r_sel && rgrp == `TCC_GRP_VALL;
        assign pbuf[c]    = ctrl_r[EVN].buf_sel;                 // [R9]

        always_comb begin
            if (ctrl_r[c].els == `TCC_ELS_OFF
                || (c % 2 == 1 && pbuf[c])) begin
                mode[c] = tcc_pkg::MODE_OFF;                     // [R8] [R13]
            end else if (pbuf[c] || ctrl_r[c].msa) begin
                mode[c] = tcc_pkg::MODE_COMPARE;                 // [R11]
            end else begin
                mode[c] = tcc_pkg::MODE_CAPTURE;                 // [R11]
            end
        end

        // Pin passes three flops; a level counts once stages 2 and 3 agree
        always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                sync_r    <= 3'h0;
                filt_r[c] <= 1'b0;
            end else begin
                sync_r <= {sync_r[1:0], channel_pin_i[c]};
                if (sync_r[1] == sync_r[2]) begin
                    filt_r[c] <= sync_r[2];
                end
            end
        end

        always_comb begin
            case (ctrl_r[c].els)
                `TCC_ELS_RISE: edge_hit = sync_r[2] && !filt_r[c];
                `TCC_ELS_FALL: edge_hit = !sync_r[2] && filt_r[c];
                default:       edge_hit = sync_r[2] != filt_r[c];  // [R14]
            endcase
        end

        assign cap_ev[c] = mode[c] == tcc_pkg::MODE_CAPTURE
                           && sync_r[1] == sync_r[2] && edge_hit
                           && !cap_blk_r[c];                     // [R21]

        // Buffered even channel compares against the active pair member
        always_comb begin
            if (c % 2 == 0 && pbuf[c]) begin
                cmp_val = val_r[c + {31'h0, act_r[PR]}];
                inhibit = hi_pend_r[c + {31'h0, act_r[PR]}];     // [R23]
            end else begin
                cmp_val = val_r[c];
                inhibit = hi_pend_r[c];                          // [R23]
            end
        end

        assign match[c] = mode[c] == tcc_pkg::MODE_COMPARE && !inhibit
                          && timer_count_value_i == cmp_val;
        assign ev[c]    = match[c] || cap_ev[c];                 // [R6]

        assign clr_req = (wr_ctrl[c] && !wbyte[`TCC_FLAG_BIT]
                          && clr_arm_r[c])                       // [R1]
                       || ((wr_lo[c] || rd_lo[c]) && ctrl_r[c].irq_en
                          && dma_r[c]);                          // [R3]

        always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                ctrl_r[c] <= `TCC_CTRL_RST;                      // [R5]
            end else begin
                if (wr_ctrl[c]) begin
                    ctrl_r[c].irq_en  <= wbyte[6];
                    ctrl_r[c].buf_sel <= (c % 2 == 0) && wbyte[5];
                    ctrl_r[c].msa     <= wbyte[4];
                    ctrl_r[c].els     <= wbyte[3:2];
                    ctrl_r[c].tov     <= wbyte[1];
                    ctrl_r[c].max     <= wbyte[0];
                end
                // Set wins over clear; writing 1 never sets
                if (ev[c]) begin
                    ctrl_r[c].flag <= 1'b1;                      // [R2] [R6]
                end else if (clr_req || (c % 2 == 1 && pbuf[c])) begin
                    ctrl_r[c].flag <= 1'b0;                      // [R5] [R8]
                end
            end
        end

        always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                clr_arm_r[c] <= 1'b0;
            end else if (ev[c] || wr_ctrl[c]) begin
                clr_arm_r[c] <= 1'b0;                            // [R2]
            end else if (rd_ctrl[c] && ctrl_r[c].flag) begin
                clr_arm_r[c] <= 1'b1;                            // [R1]
            end
        end

        // Value holds no reset: its content is undefined until written or loaded by a capture
        always_ff @(posedge ref_clk_i) begin
            if (wr_hi[c]) begin
                val_r[c][CNT_W-1:`TCC_BYTE_W] <= wbyte;          // [R22]
            end else if (wr_lo[c]) begin
                val_r[c][`TCC_BYTE_W-1:0] <= wbyte;              // [R22]
            end else if (cap_ev[c]) begin
                val_r[c] <= timer_count_value_i;                 // [R20]
            end
        end

        always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                hi_pend_r[c] <= 1'b0;
                cap_blk_r[c] <= 1'b0;
            end else begin
                if (wr_hi[c]) begin
                    hi_pend_r[c] <= 1'b1;
                end else if (wr_lo[c]) begin
                    hi_pend_r[c] <= 1'b0;
                end
                if (rd_lo[c] || mode[c] != tcc_pkg::MODE_CAPTURE) begin
                    cap_blk_r[c] <= 1'b0;
                end else if (rd_hi[c]) begin
                    cap_blk_r[c] <= 1'b1;                        // [R21]
                end
            end
        end

        always_comb begin
            out_nxt[c] = out_r[c];
            if (ctrl_r[c].els == `TCC_ELS_OFF) begin
                out_nxt[c] = !ctrl_r[c].msa;                     // [R10]
            end else if (mode[c] == tcc_pkg::MODE_COMPARE) begin
                if (timer_ovf_i && ctrl_r[c].tov) begin
                    out_nxt[c] = !out_r[c];                      // [R17] [R18]
                end else if (match[c]) begin
                    case (ctrl_r[c].els)
                        `TCC_ELS_TOGGLE: out_nxt[c] = !out_r[c]; // [R15]
                        `TCC_ELS_CLEAR:  out_nxt[c] = 1'b0;
                        default:         out_nxt[c] = 1'b1;
                    endcase
                end
            end
        end

        always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                out_r[c] <= 1'b0;
                pin_r    <= 1'b0;
                oe_r     <= 1'b0;
                irq_r    <= 1'b0;
                dreq_r   <= 1'b0;
            end else begin
                out_r[c] <= out_nxt[c];
                pin_r    <= ctrl_r[c].max ? 1'b1 : out_r[c];     // [R19]
                oe_r     <= mode[c] == tcc_pkg::MODE_COMPARE;    // [R13]
                // Buffered channels always go to the CPU
                irq_r  <= ctrl_r[c].flag && ctrl_r[c].irq_en
                          && (!dma_r[c] || pbuf[c]);             // [R7]
                dreq_r <= ctrl_r[c].flag && ctrl_r[c].irq_en
                          && dma_r[c] && !pbuf[c];               // [R7] [R4]
            end
        end

        assign channel_pin_o[c]    = pin_r;
        assign channel_pin_oe_o[c] = oe_r;
        assign cpu_irq_o[c]        = irq_r;
        assign dma_req_o[c]        = dreq_r;

        flag_set_a: assert property (                          // [R2]
            @(posedge ref_clk_i) disable iff (!reset_n_i)
            ev[c] |=> ctrl_r[c].flag)
            else $error("flag lost after channel event");
        flag_wone_a: assert property (                         // [R5]
            @(posedge ref_clk_i) disable iff (!reset_n_i)
            !ctrl_r[c].flag && !ev[c] |=> !ctrl_r[c].flag)
            else $error("flag set without an event");
        dma_clear_a: assert property (                         // [R3]
            @(posedge ref_clk_i) disable iff (!reset_n_i)
            rd_lo[c] && ctrl_r[c].irq_en && dma_r[c] && !ev[c]
            |=> !ctrl_r[c].flag)
            else $error("low byte access did not clear flag");
        irq_gate_a: assert property (                          // [R7]
            @(posedge ref_clk_i) disable iff (!reset_n_i)
            !ctrl_r[c].irq_en |=> !cpu_irq_o[c] && !dma_req_o[c])
            else $error("request while channel disabled");
        pin_release_a: assert property (                       // [R13]
            @(posedge ref_clk_i) disable iff (!reset_n_i)
            ctrl_r[c].els == `TCC_ELS_OFF |=> !channel_pin_oe_o[c])
            else $error("pin driven with edge/level off");
        cap_latch_a: assert property (                         // [R20]
            @(posedge ref_clk_i) disable iff (!reset_n_i)
            cap_ev[c] && !wr_hi[c] && !wr_lo[c]
            |=> val_r[c] == $past(timer_count_value_i))
            else $error("capture did not latch counter");
        ovf_first_a: assert property (                         // [R18]
            @(posedge ref_clk_i) disable iff (!reset_n_i)
            mode[c] == tcc_pkg::MODE_COMPARE && timer_ovf_i
            && ctrl_r[c].tov && ctrl_r[c].els != `TCC_ELS_OFF
            |=> out_r[c] != $past(out_r[c]))
            else $error("overflow toggle lost to match");
        full_duty_a: assert property (                         // [R19]
            @(posedge ref_clk_i) disable iff (!reset_n_i)
            ctrl_r[c].max |=> channel_pin_o[c])
            else $error("full duty did not force pin high");
        if (c % 2 == 1) begin : g_odd
            odd_off_a: assert property (                       // [R8]
                @(posedge ref_clk_i) disable iff (!reset_n_i)
                pbuf[c] |=> !channel_pin_oe_o[c] && !ctrl_r[c].flag
                            || ev[c])
                else $error("partner active while pair buffered");
        end
    end

endmodule : tcc_top

// file: verif/tcc_far_model.sv
// Far side: shared counter with overflow pulse, resolved channel pin wires
`timescale 1ns/10ps
module tcc_far_model #(
    parameter int MOD = 63
) (
    input  wire logic        clk_i,      // Bench clock
    input  wire logic        reset_n_i,  // Async reset
    input  wire logic        run_i,      // Counter runs
    input  wire logic        load_i,     // Preload strobe
    input  wire logic [15:0] load_val_i, // Preload value
    input  wire logic [3:0]  drv_i,      // External pin level
    input  wire logic [3:0]  pin_o_i,    // Device pin level
    input  wire logic [3:0]  pin_oe_i,   // Device drive enable
    output logic [15:0]      count_o,    // Shared counter
    output logic             ovf_o,      // Overflow pulse
    output logic [3:0]       pin_o       // Wire level seen
);
    // Frozen counter stands in for a stopped timer
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_o <= 16'h0000;
            ovf_o   <= 1'b0;
        end else begin
            ovf_o <= run_i && count_o == 16'(MOD);
            if (load_i) count_o <= load_val_i;
            else if (run_i)
                count_o <= (count_o == 16'(MOD)) ? '0 : count_o + 16'h0001;
        end
    end
    // External level only moves on bench steps of many clocks
    assign pin_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & drv_i);
endmodule : tcc_far_model

// file: verif/testbench.sv
// Self-checking bench for the timer channel block
`timescale 1ns/10ps
module testbench;
    logic ref_clk_i, reset_n_i, s_axi_awvalid_i, s_axi_wvalid_i, run, ld;
    logic s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i, timer_ovf_i;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_rvalid_o;
    logic        s_axi_arready_o;
    logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
    logic [3:0]  s_axi_wstrb_i, channel_pin_i, channel_pin_o, drv;
    logic [3:0]  channel_pin_oe_o, cpu_irq_o, dma_req_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    logic [15:0] timer_count_value_i, ldv;
    logic [33:0] exp_q[$];
    int          n_fail, num_checks;
    tcc_top dut (.ref_clk_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
        .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
        .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
        .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
        .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .timer_count_value_i,
        .timer_ovf_i, .channel_pin_i, .channel_pin_o, .channel_pin_oe_o,
        .cpu_irq_o, .dma_req_o);
    tcc_far_model far (.clk_i(ref_clk_i), .reset_n_i, .run_i(run), .load_i(ld),
        .load_val_i(ldv), .drv_i(drv), .pin_o_i(channel_pin_o),
        .pin_oe_i(channel_pin_oe_o), .count_o(timer_count_value_i),
        .ovf_o(timer_ovf_i), .pin_o(channel_pin_i));
    task automatic wrap_up;
        if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    task automatic cmp(input string nm, input logic [33:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : tick
    task automatic wr(input logic [7:0] a, d, input logic [1:0] r = 2'h0);
        int k;
        exp_q.push_back({r, 32'h0});
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= {24'h0, d};
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'b111;
        do begin
            @(posedge ref_clk_i);
            k++;
            if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
        end while (s_axi_bvalid_o !== 1'b1 && k < 40);
        if (k == 40) begin
            cmp("bvalid", 1, 0);
            wrap_up();
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, d, input logic [1:0] r = 2'h0);
        int k;
        exp_q.push_back({r, 24'h0, d});
        s_axi_araddr_i <= a;
        {s_axi_arvalid_i, s_axi_rready_i} <= 2'b11;
        do begin
            @(posedge ref_clk_i);
            k++;
            if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
        end while (s_axi_rvalid_o !== 1'b1 && k < 40);
        if (k == 40) begin
            cmp("rvalid", 1, 0);
            wrap_up();
        end
    endtask : rd
    task automatic wait_irq(input int ch);
        int k;
        while (cpu_irq_o[ch] !== 1'b1 && k < 300) begin
            @(posedge ref_clk_i);
            k++;
        end
        if (k == 300) begin
            cmp("irq", 1, 0);
            wrap_up();
        end
    endtask : wait_irq
    task automatic load(input logic [15:0] x);
        ldv <= x;
        ld <= 1'b1;
        tick(1);
        ld <= 1'b0;
    endtask : load
    task automatic pulse;
        drv[1] <= 1'b0;
        tick(10);
        drv[1] <= 1'b1;
        tick(10);
    endtask : pulse
    // Scoreboard: oldest note meets each bus answer
    always @(posedge ref_clk_i) begin
        if (s_axi_rvalid_o && s_axi_rready_i)
            cmp("rdata", exp_q.pop_front(), {s_axi_rresp_o, s_axi_rdata_o});
        if (s_axi_bvalid_o && s_axi_bready_i)
            cmp("bresp", exp_q.pop_front(), {s_axi_bresp_o, 32'h0});
    end
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        logic [15:0] v, w;
        {w, v} = $urandom(32'h2d781eb5);
        {reset_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
        {s_axi_arvalid_i, s_axi_rready_i, run, ld, drv, ldv} = '0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
        s_axi_wstrb_i = 4'hF;
        tick(2);
        reset_n_i <= 1'b1;
        tick(1);
        for (int i = 0; i < 4; i++) rd(8'(4 * i), 8'h00);
        rd(8'h30, 8'h00);
        rd(8'h40, 8'h00, 2'h2);
        wr(8'h44, 8'h01, 2'h2);
        wr(8'h08, 8'hA0);
        rd(8'h08, 8'h20);
        wr(8'h0C, 8'h20);
        rd(8'h0C, 8'h00);
        load(v);
        wr(8'h04, 8'h44);
        tick(2);
        drv[1] <= 1'b1;
        wait_irq(1);
        rd(8'h04, 8'hC4);
        wr(8'h04, 8'h44);
        rd(8'h04, 8'h44);
        rd(8'h14, v[15:8]);
        load(w);
        pulse();
        rd(8'h24, v[7:0]);
        pulse();
        rd(8'h14, w[15:8]);
        rd(8'h24, w[7:0]);
        wait_irq(1);
        rd(8'h04, 8'hC4);
        pulse();
        wr(8'h04, 8'h44);
        rd(8'h04, 8'hC4);
        wr(8'h14, 8'hA5);
        rd(8'h14, 8'hA5);
        load(16'h0000);
        run <= 1'b1;
        wr(8'h00, 8'h10);
        tick(3);
        cmp("pin0", 2'b00, {channel_pin_o[0], channel_pin_oe_o[0]});
        wr(8'h10, 8'h00);
        wr(8'h20, 8'h20);
        wr(8'h00, 8'h5C);
        wait_irq(0);
        run <= 1'b0;
        cmp("pin0", 2'b11, {channel_pin_o[0], channel_pin_oe_o[0]});
        wr(8'h30, 8'h01);
        tick(2);
        cmp("req0", 2'b10, {dma_req_o[0], cpu_irq_o[0]});
        rd(8'h20, 8'h20);
        rd(8'h00, 8'h5C);
        wr(8'h30, 8'h00);
        wr(8'h20, 8'h00);
        wr(8'h00, 8'h5A);
        run <= 1'b1;
        wait_irq(0);
        cmp("pin0", 2'b01, {channel_pin_o[0], channel_pin_oe_o[0]});
        tick(64);
        cmp("pin0", 2'b11, {channel_pin_o[0], channel_pin_oe_o[0]});
        wr(8'h00, 8'h5B);
        tick(64);
        cmp("pin0", 2'b11, {channel_pin_o[0], channel_pin_oe_o[0]});
        wrap_up();
    end
endmodule : testbench
